// >>> e3ra_alarm.sv
// Function
// [R1] cell sync lost while a header check error is seen within seven cells.
// [R2] remote defect raised when the received remote defect field is all ones.
// [R3] alarm indication when out of frame and under eight zeros in one frame.
// [R4] cell sync indicator shows history after any cell sync defect since clear.
// [R5] remote defect indicator is active while far end failures are current.
// [R6] remote defect indicator latches history after any far end failure.
// [R7] alarm indication indicator rests at off, never clear, when no alarm seen.
// [R8] when filtering, idle and unassigned cells on selected port are discarded; the code discards only idle cells, as it has no unassigned cell input.
// [R9] all history is cleared on test restart or statistics reset.
// [R10] each of the two receivers keeps its own independent indicator set.
// [R11] out of frame entered after four consecutive framing pattern errors.
// [R12] indicator shows active if current, else history if latched, else clear.
`timescale 1ns/1ps
module e3ra_alarm #(
    parameter int unsigned NRX   = e3ra_pkg::NUM_RX,
    parameter int unsigned RDI_W = e3ra_pkg::RDI_BITS,
    parameter int unsigned SEL_W = (NRX > 1) ? $clog2(NRX) : 1
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    input  wire logic                      i_test_restart,
    input  wire logic                      i_stats_reset,
    input  wire logic                      i_filter_en,
    input  wire logic [SEL_W-1:0]          i_filter_sel,
    input  wire logic [NRX-1:0]            i_cell_valid,
    input  wire logic [NRX-1:0]            i_cell_hec_err,
    input  wire logic [NRX-1:0]            i_cell_idle,
    input  wire logic [NRX-1:0]            i_frame_end,
    input  wire logic [NRX-1:0]            i_frame_err,
    input  wire logic [NRX-1:0]            i_bit_valid,
    input  wire logic [NRX-1:0]            i_bit,
    input  wire logic [NRX-1:0][RDI_W-1:0] i_rdi_field,
    output logic      [NRX-1:0]            o_cell_pass,
    output logic      [NRX-1:0]            o_oof,
    output e3ra_pkg::e3ra_ind_t            o_frame_ind [NRX],
    output e3ra_pkg::e3ra_ind_t            o_cell_ind  [NRX],
    output e3ra_pkg::e3ra_ind_t            o_rdi_ind   [NRX],
    output e3ra_pkg::e3ra_ind_t            o_ais_ind   [NRX]
);
    import e3ra_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (NRX < 1 || NRX > (1 << SEL_W) || RDI_W < 1) begin : g_bad_param
        $error("e3ra_alarm: unsupported receiver count or field width");
    end

    logic hist_clr;
    assign hist_clr = i_test_restart | i_stats_reset; // R9

    // ------------------------------------------------------------
    // per receiver detection
    // ------------------------------------------------------------
    for (genvar i = 0; i < NRX; i++) begin : g_rx // R10
        logic [LCD_CELLS-1:0] win_q;
        logic [LCD_CELLS-1:0] win_d;
        logic [FERR_W-1:0]    ferr_q;
        logic [FERR_W-1:0]    ferr_d;
        logic [ZCNT_W-1:0]    zcnt_q;
        logic [ZCNT_W-1:0]    zcnt_d;
        logic [ZCNT_W-1:0]    z_now;
        logic                 oof_q;
        logic                 oof_d;
        logic                 ais_q;
        logic                 ais_d;
        logic                 rdi_q;
        logic                 rdi_d;
        logic                 lcd_q;
        logic                 lcd_d;
        logic                 pass_q;
        logic                 pass_d;
        logic                 drop;

        always_comb begin
            win_d  = win_q;
            ferr_d = ferr_q;
            oof_d  = oof_q;
            ais_d  = ais_q;
            rdi_d  = rdi_q;
            if (i_cell_valid[i]) begin
                win_d = {win_q[LCD_CELLS-2:0], i_cell_hec_err[i]}; // R1
            end
            lcd_d = |win_d; // R1
            // zero count saturates; only below-eight matters
            z_now = zcnt_q;
            if (i_bit_valid[i] && !i_bit[i] && zcnt_q < ZCNT_AIS) begin
                z_now = zcnt_q + 4'h1; // R3
            end
            zcnt_d = z_now;
            if (i_frame_end[i]) begin
                zcnt_d = ZCNT_RST;
                if (i_frame_err[i]) begin
                    if (ferr_q < FERR_OOF) begin
                        ferr_d = ferr_q + 3'h1; // R11
                    end
                end else begin
                    ferr_d = FERR_RST;
                end
                oof_d = (ferr_d >= FERR_OOF); // R11
                ais_d = oof_q && (z_now < ZCNT_AIS); // R3
                rdi_d = &i_rdi_field[i]; // R2
            end
            drop   = i_filter_en && (i_filter_sel == SEL_W'(i)) && i_cell_idle[i]; // R8
            pass_d = i_cell_valid[i] && !drop; // R8
        end

        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                win_q  <= '0;
                ferr_q <= FERR_RST;
                zcnt_q <= ZCNT_RST;
                oof_q  <= FLAG_RST;
                ais_q  <= FLAG_RST;
                rdi_q  <= FLAG_RST;
                lcd_q  <= FLAG_RST;
                pass_q <= FLAG_RST;
            end else begin
                win_q  <= win_d;
                ferr_q <= ferr_d;
                zcnt_q <= zcnt_d;
                oof_q  <= oof_d;
                ais_q  <= ais_d;
                rdi_q  <= rdi_d;
                lcd_q  <= lcd_d;
                pass_q <= pass_d;
            end
        end

        assign o_oof[i]       = oof_q;
        assign o_cell_pass[i] = pass_q;

        // ------------------------------------------------------------
        // indicators
        // ------------------------------------------------------------
        e3ra_indicator #(.CLEAR_STATE(IND_CLEAR)) u_frame_ind (
            .i_clk        (i_clk),
            .i_arst_n     (i_arst_n),
            .i_defect     (oof_q),
            .i_clear_hist (hist_clr),
            .o_state      (o_frame_ind[i])
        );
        e3ra_indicator #(.CLEAR_STATE(IND_CLEAR)) u_cell_ind (
            .i_clk        (i_clk),
            .i_arst_n     (i_arst_n),
            .i_defect     (lcd_q),
            .i_clear_hist (hist_clr),
            .o_state      (o_cell_ind[i])
        );
        e3ra_indicator #(.CLEAR_STATE(IND_CLEAR)) u_rdi_ind (
            .i_clk        (i_clk),
            .i_arst_n     (i_arst_n),
            .i_defect     (rdi_q),
            .i_clear_hist (hist_clr),
            .o_state      (o_rdi_ind[i])
        );
        // alarm indication rests at off rather than clear
        e3ra_indicator #(.CLEAR_STATE(IND_OFF)) u_ais_ind (
            .i_clk        (i_clk),
            .i_arst_n     (i_arst_n),
            .i_defect     (ais_q),
            .i_clear_hist (hist_clr),
            .o_state      (o_ais_ind[i])
        );

        // ------------------------------------------------------------
        // assertions
        // ------------------------------------------------------------
        sequence s_rdi_fall;
            rdi_q ##1 (!rdi_q && !hist_clr);
        endsequence
        sequence s_lcd_fall;
            lcd_q ##1 (!lcd_q && !hist_clr);
        endsequence

        property p_lcd_set;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_cell_valid[i] && i_cell_hec_err[i]) |=> lcd_q ##1 (o_cell_ind[i] == IND_ACTIVE);
        endproperty
        a_lcd_set: assert property (p_lcd_set) // R1
            else $error("cell sync loss not flagged after header error");

        property p_oof_enter;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_frame_end[i] && i_frame_err[i] && ferr_q == FERR_OOF - 3'h1) |=> o_oof[i];
        endproperty
        a_oof_enter: assert property (p_oof_enter) // R11
            else $error("out of frame not entered on fourth framing error");

        property p_oof_early;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_frame_end[i] && ferr_q < FERR_OOF - 3'h1) |=> !o_oof[i];
        endproperty
        a_oof_early: assert property (p_oof_early) // R11
            else $error("out of frame entered too early");

        property p_rdi_active;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_frame_end[i] && (&i_rdi_field[i])) |=> ##1 (o_rdi_ind[i] == IND_ACTIVE);
        endproperty
        a_rdi_active: assert property (p_rdi_active) // R2
            else $error("remote defect indicator not active");

        property p_rdi_hist;
            @(posedge i_clk) disable iff (!i_arst_n)
            s_rdi_fall |=> (o_rdi_ind[i] == IND_HISTORY);
        endproperty
        a_rdi_hist: assert property (p_rdi_hist) // R6
            else $error("remote defect history not latched");

        property p_lcd_hist;
            @(posedge i_clk) disable iff (!i_arst_n)
            s_lcd_fall |=> (o_cell_ind[i] == IND_HISTORY);
        endproperty
        a_lcd_hist: assert property (p_lcd_hist) // R4
            else $error("cell sync history not latched");

        property p_ais_needs_oof;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_frame_end[i] && !o_oof[i]) |=> ##1 (o_ais_ind[i] != IND_ACTIVE);
        endproperty
        a_ais_needs_oof: assert property (p_ais_needs_oof) // R3
            else $error("alarm indication raised outside out of frame");

        property p_ais_never_clear;
            @(posedge i_clk) disable iff (!i_arst_n)
            o_ais_ind[i] != IND_CLEAR;
        endproperty
        a_ais_never_clear: assert property (p_ais_never_clear) // R7
            else $error("alarm indication indicator shows clear");

        property p_hist_clear;
            @(posedge i_clk) disable iff (!i_arst_n)
            (hist_clr && !rdi_q) |=> (o_rdi_ind[i] == IND_CLEAR);
        endproperty
        a_hist_clear: assert property (p_hist_clear) // R9
            else $error("remote defect history not cleared");

        property p_filter;
            @(posedge i_clk) disable iff (!i_arst_n)
            (i_filter_en && i_filter_sel == SEL_W'(i) && i_cell_idle[i]) |=> !o_cell_pass[i];
        endproperty
        a_filter: assert property (p_filter) // R8
            else $error("filtered idle cell passed");
    end

endmodule : e3ra_alarm

// >>> e3ra_indicator.sv
`timescale 1ns/1ps
module e3ra_indicator #(
    parameter e3ra_pkg::e3ra_ind_t CLEAR_STATE = e3ra_pkg::IND_CLEAR
) (
    input  wire logic          i_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_defect,
    input  wire logic          i_clear_hist,
    output e3ra_pkg::e3ra_ind_t o_state
);
    import e3ra_pkg::*;

    logic      hist_q;
    logic      hist_d;
    e3ra_ind_t state_q;
    e3ra_ind_t state_d;

    // ------------------------------------------------------------
    // history latch and state select
    // ------------------------------------------------------------
    always_comb begin
        // a defect in the clearing cycle still leaves history
        hist_d = i_defect | (hist_q & ~i_clear_hist); // R4 R6 R9
        if (i_defect) begin
            state_d = IND_ACTIVE; // R12 R5
        end else if (hist_d) begin
            state_d = IND_HISTORY; // R12
        end else begin
            state_d = CLEAR_STATE; // R12 R7
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist_q  <= FLAG_RST;
            state_q <= CLEAR_STATE;
        end else begin
            hist_q  <= hist_d;
            state_q <= state_d;
        end
    end

    assign o_state = state_q;

endmodule : e3ra_indicator

// >>> e3ra_line_model.sv
`timescale 1ns/1ps
module e3ra_line_model #(
    parameter int unsigned NRX   = 2,
    parameter int unsigned RDI_W = 3
) (
    input  wire logic                      i_clk,
    output logic      [NRX-1:0]            o_cell_valid,
    output logic      [NRX-1:0]            o_cell_hec_err,
    output logic      [NRX-1:0]            o_cell_idle,
    output logic      [NRX-1:0]            o_frame_end,
    output logic      [NRX-1:0]            o_frame_err,
    output logic      [NRX-1:0]            o_bit_valid,
    output logic      [NRX-1:0]            o_bit,
    output logic      [NRX-1:0][RDI_W-1:0] o_rdi_field
);
    localparam int FRAME_BITS = 12;

    initial begin
        {o_cell_valid, o_cell_hec_err, o_cell_idle, o_frame_end} = '0;
        {o_frame_err, o_bit_valid, o_bit} = '0;
        o_rdi_field = '0;
    end

    // ------------------------------------------------------------
    // one cell, then a quiet cycle; unqualified lines flip so stale values never look valid
    // ------------------------------------------------------------
    task automatic send_cell(input int rx, input logic hec, input logic idle);
        @(posedge i_clk);
        #1;
        o_cell_valid[rx]   = 1'h1;
        o_cell_hec_err[rx] = hec;
        o_cell_idle[rx]    = idle;
        @(posedge i_clk);
        #1;
        o_cell_valid[rx]   = 1'h0;
        o_cell_hec_err[rx] = ~hec;
        o_cell_idle[rx]    = ~idle;
    endtask : send_cell

    // ------------------------------------------------------------
    // one frame: zeros first, then ones; frame end rides on the last bit
    // ------------------------------------------------------------
    task automatic send_frame(input int rx, input logic err, input int zeros,
                              input logic [RDI_W-1:0] rdi);
        for (int i = 0; i < FRAME_BITS; i++) begin
            @(posedge i_clk);
            #1;
            o_bit_valid[rx] = 1'h1;
            o_bit[rx]       = (i >= zeros);
            if (i == FRAME_BITS - 1) begin
                o_frame_end[rx] = 1'h1;
                o_frame_err[rx] = err;
                o_rdi_field[rx] = rdi;
            end
        end
        @(posedge i_clk);
        #1;
        o_bit_valid[rx] = 1'h0;
        o_bit[rx]       = ~o_bit[rx];
        o_frame_end[rx] = 1'h0;
        o_frame_err[rx] = ~err;
        o_rdi_field[rx] = ~rdi;
    endtask : send_frame
endmodule : e3ra_line_model

// >>> e3ra_pkg.sv
package e3ra_pkg;

    // ------------------------------------------------------------
    // indicator states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IND_CLEAR,
        IND_HISTORY,
        IND_ACTIVE,
        IND_OFF
    } e3ra_ind_t;

    // ------------------------------------------------------------
    // counts and widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_RX     = 2;
    localparam int unsigned RDI_BITS   = 3;
    localparam int unsigned LCD_CELLS  = 7;
    localparam int unsigned OOF_FRAMES = 4;
    localparam int unsigned AIS_ZEROS  = 8;
    localparam int unsigned FERR_W     = 3;
    localparam int unsigned ZCNT_W     = 4;

    localparam logic [FERR_W-1:0] FERR_OOF   = FERR_W'(OOF_FRAMES);
    localparam logic [FERR_W-1:0] FERR_RST   = 3'h0;
    localparam logic [ZCNT_W-1:0] ZCNT_AIS   = ZCNT_W'(AIS_ZEROS);
    localparam logic [ZCNT_W-1:0] ZCNT_RST   = 4'h0;
    localparam logic              FLAG_RST   = 1'h0;

endpackage : e3ra_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import e3ra_pkg::*;
    logic            clk, arst_n, test_restart, stats_reset, filter_en;
    logic [0:0]      filter_sel;
    logic [1:0]      cell_valid, hec_err, cell_idle, frame_end, frame_err;
    logic [1:0]      bit_valid, line_bit, cell_pass, oof;
    logic [1:0][2:0] rdi_field;
    e3ra_ind_t       frame_ind [2];
    e3ra_ind_t       cell_ind [2];
    e3ra_ind_t       rdi_ind [2];
    e3ra_ind_t       ais_ind [2];
    int              num_errors = 0;
    int              n_tests = 0;
    int              cyc = 0;

    e3ra_alarm DUT (.i_clk(clk), .i_arst_n(arst_n), .i_test_restart(test_restart),
        .i_stats_reset(stats_reset), .i_filter_en(filter_en), .i_filter_sel(filter_sel),
        .i_cell_valid(cell_valid), .i_cell_hec_err(hec_err), .i_cell_idle(cell_idle),
        .i_frame_end(frame_end), .i_frame_err(frame_err), .i_bit_valid(bit_valid),
        .i_bit(line_bit), .i_rdi_field(rdi_field), .o_cell_pass(cell_pass), .o_oof(oof),
        .o_frame_ind(frame_ind), .o_cell_ind(cell_ind), .o_rdi_ind(rdi_ind),
        .o_ais_ind(ais_ind));

    e3ra_line_model u_line (.i_clk(clk), .o_cell_valid(cell_valid), .o_cell_hec_err(hec_err),
        .o_cell_idle(cell_idle), .o_frame_end(frame_end), .o_frame_err(frame_err),
        .o_bit_valid(bit_valid), .o_bit(line_bit), .o_rdi_field(rdi_field));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_ind(input string what, input e3ra_ind_t exp, input e3ra_ind_t got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_ind

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 2; i++) begin
            chk_ind("cell ind", IND_CLEAR, cell_ind[i]);
            chk_ind("rdi ind", IND_CLEAR, rdi_ind[i]);
            chk_ind("ais ind", IND_OFF, ais_ind[i]);
            chk_ind("frame ind", IND_CLEAR, frame_ind[i]);
            chk_bit("oof", 1'h0, oof[i]);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_cell_sync;
        u_line.send_cell(0, 1'h1, 1'h0);
        chk_bit("cell pass", 1'h1, cell_pass[0]);
        wait_cyc(1);
        chk_ind("cell ind", IND_ACTIVE, cell_ind[0]);
        for (int i = 0; i < 6; i++) u_line.send_cell(0, 1'h0, 1'h0);
        chk_ind("cell ind six clean", IND_ACTIVE, cell_ind[0]);
        u_line.send_cell(0, 1'h0, 1'h0);
        wait_cyc(1);
        chk_ind("cell ind seven clean", IND_HISTORY, cell_ind[0]);
        chk_ind("other rx cell ind", IND_CLEAR, cell_ind[1]);
        $display("test cell sync done");
    endtask : t_cell_sync

    task automatic t_rdi;
        u_line.send_frame(1, 1'h0, 0, 3'h7);
        wait_cyc(1);
        chk_ind("rdi ind", IND_ACTIVE, rdi_ind[1]);
        chk_ind("other rx rdi ind", IND_CLEAR, rdi_ind[0]);
        u_line.send_frame(1, 1'h0, 0, 3'h6);
        wait_cyc(1);
        chk_ind("rdi ind", IND_HISTORY, rdi_ind[1]);
        $display("test rdi done");
    endtask : t_rdi

    task automatic t_oof_ais;
        // a good frame in the middle must restart the count of bad frames
        logic [7:0] errs = 8'hf7;
        logic [7:0] exps = 8'h80;
        for (int i = 0; i < 8; i++) begin
            u_line.send_frame(0, errs[i], 12, 3'h0);
            chk_bit("oof", exps[i], oof[0]);
        end
        wait_cyc(1);
        chk_ind("frame ind", IND_ACTIVE, frame_ind[0]);
        chk_ind("other rx frame ind", IND_CLEAR, frame_ind[1]);
        u_line.send_frame(0, 1'h1, 8, 3'h0);
        wait_cyc(1);
        chk_ind("ais ind eight zeros", IND_OFF, ais_ind[0]);
        u_line.send_frame(0, 1'h1, 7, 3'h0);
        wait_cyc(1);
        chk_ind("ais ind seven zeros", IND_ACTIVE, ais_ind[0]);
        chk_ind("other rx ais ind", IND_OFF, ais_ind[1]);
        u_line.send_frame(0, 1'h0, 12, 3'h0);
        chk_bit("oof", 1'h0, oof[0]);
        wait_cyc(1);
        chk_ind("ais ind", IND_HISTORY, ais_ind[0]);
        chk_ind("frame ind", IND_HISTORY, frame_ind[0]);
        $display("test oof ais done");
    endtask : t_oof_ais

    task automatic t_clear;
        stats_reset = 1'h1;
        wait_cyc(1);
        stats_reset = 1'h0;
        chk_ind("cell ind", IND_CLEAR, cell_ind[0]);
        chk_ind("ais ind", IND_OFF, ais_ind[0]);
        chk_ind("rdi ind", IND_CLEAR, rdi_ind[1]);
        chk_ind("frame ind", IND_CLEAR, frame_ind[0]);
        u_line.send_frame(0, 1'h0, 0, 3'h7);
        u_line.send_frame(0, 1'h0, 0, 3'h0);
        chk_ind("rdi ind current", IND_ACTIVE, rdi_ind[0]);
        test_restart = 1'h1;
        wait_cyc(1);
        test_restart = 1'h0;
        chk_ind("rdi ind", IND_CLEAR, rdi_ind[0]);
        $display("test clear done");
    endtask : t_clear

    task automatic t_filter;
        logic [4:0] f_en   = 5'h0f;
        logic [4:0] f_sel  = 5'h08;
        logic [4:0] f_rx   = 5'h0a;
        logic [4:0] f_idle = 5'h1b;
        logic [4:0] f_exp  = 5'h16;
        for (int i = 0; i < 5; i++) begin
            filter_en  = f_en[i];
            filter_sel = f_sel[i];
            u_line.send_cell(int'(f_rx[i]), 1'h0, f_idle[i]);
            chk_bit("cell pass", f_exp[i], cell_pass[f_rx[i]]);
        end
        $display("test filter done");
    endtask : t_filter

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            $display("[FAIL] run length expected under 3000 cycles seen 3000");
            test_done();
        end
    end

    initial begin
        {arst_n, test_restart, stats_reset, filter_en} = '0;
        filter_sel = '0;
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'h1;
        t_reset();
        t_cell_sync();
        t_rdi();
        t_oof_ais();
        t_clear();
        t_filter();
        test_done();
    end
endmodule : tb
